// [dbgw_core.sv]
`timescale 1ns/1ns
`default_nettype none
module dbgw_core
	import dbgw_pkg::*;
#(
	parameter logic [15:0] REVISION = 16'h0100  // Arbitrary value
) (
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic            rx_valid,
	input  wire logic [7:0]      rx_byte,
	output logic                 tx_valid,
	output logic [7:0]           tx_byte,
	input  wire logic            tx_ready,
	input  wire logic            debug_mode,
	input  wire dbgw_rf_access_t rf_access,
	output logic                 watch_break,
	output logic [7:0]           debugger_status_byte
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RECV = 3'b010,
		ST_SEND = 3'b100
	} dbgw_state_t;

	dbgw_state_t state_r;
	dbgw_state_t state_nxt;
	dbgw_watch_t watch_r;
	dbgw_watch_t watch_nxt;
	logic [23:0] resp_r;
	logic [23:0] resp_nxt;
	logic [1:0]  cnt_r;
	logic [1:0]  cnt_nxt;
	logic [15:0] runtime_r;
	logic [15:0] runtime_nxt;
	logic        dbg_q_r;
	logic        hit_r;
	logic        break_r;
	logic        stat_ans_r;
	logic        stat_ans_nxt;
	logic        cmd_take;
	logic        data_take;
	logic        send_pop;
	logic        status_done;
	logic [11:0] match_addr;
	logic        data_match_en;
	logic        addr_hit;
	logic        data_ok;
	logic        watch_hit;
	logic        run_start;

	function automatic logic cmd_overwrites(input logic [7:0] c);
		cmd_overwrites = (c >= CMD_WR_REG && c <= CMD_RD_CRC) ||
			(c >= CMD_STEP && c <= CMD_EXEC);
	endfunction : cmd_overwrites

	// Link handshake qualifiers
	assign cmd_take  = (state_r == ST_IDLE) && rx_valid;
	assign data_take = (state_r == ST_RECV) && rx_valid;
	assign send_pop  = (state_r == ST_SEND) && tx_ready;

	// Hit clears only when a status answer is taken, whatever its value
	assign status_done = send_pop && (cnt_r == 2'd1) && stat_ans_r;

	// Watchpoint compare
	assign match_addr    = {watch_r.control[CTL_ADDR_HI_MSB:0], watch_r.addr_low};
	assign data_match_en = watch_r.control[CTL_DATA_MATCH_BIT];
	assign addr_hit      = rf_access.valid && (rf_access.addr == match_addr);
	assign data_ok       = !data_match_en || (rf_access.data == watch_r.data);
	assign watch_hit     = watch_r.control[CTL_WATCH_EN_BIT] && addr_hit && data_ok;

	// Leaving debug mode starts a fresh measurement
	assign run_start = dbg_q_r && !debug_mode;

	assign debugger_status_byte = {debug_mode, hit_r, 6'b00_0000};
	assign tx_valid             = (state_r == ST_SEND);
	assign tx_byte              = resp_r[23:16];
	assign watch_break          = break_r;

	// Command decode and answer loading
	always_comb begin
		state_nxt = state_r;
		resp_nxt  = resp_r;
		cnt_nxt   = cnt_r;
		watch_nxt = watch_r;
		stat_ans_nxt = stat_ans_r;
		if (cmd_take) begin
			unique case (rx_byte)
				CMD_READ_REV: begin
					resp_nxt  = {REVISION[15:8], REVISION[7:0], 8'h00};
					cnt_nxt   = 2'd2;
					state_nxt = ST_SEND;
				end
				CMD_READ_STATUS: begin
					resp_nxt  = {debugger_status_byte, 16'h0000};
					cnt_nxt   = 2'd1;
					stat_ans_nxt = 1'b1;
					state_nxt = ST_SEND;
				end
				CMD_READ_RUNTIME: begin
					resp_nxt  = {runtime_r, 8'h00};
					cnt_nxt   = 2'd2;
					state_nxt = ST_SEND;
				end
				CMD_WR_WATCH: begin
					cnt_nxt   = WATCH_BYTES;
					state_nxt = ST_RECV;
				end
				CMD_RD_WATCH: begin
					resp_nxt  = watch_r;
					cnt_nxt   = WATCH_BYTES;
					state_nxt = ST_SEND;
				end
				default: begin
					state_nxt = ST_IDLE;
				end
			endcase
		end else if (data_take) begin
			resp_nxt = {resp_r[15:0], rx_byte};
			cnt_nxt  = cnt_r - 2'd1;
			if (cnt_r == 2'd1) begin
				watch_nxt = {resp_r[15:0], rx_byte};
				state_nxt = ST_IDLE;
			end
		end else if (send_pop) begin
			resp_nxt = {resp_r[15:0], 8'h00};
			cnt_nxt  = cnt_r - 2'd1;
			if (cnt_r == 2'd1) begin
				stat_ans_nxt = 1'b0;
				state_nxt = ST_IDLE;
			end
		end
	end

	// Runtime counter: restarts when the core leaves debug mode or takes a register, program, CRC, step or exec command, otherwise holds while halted
	always_comb begin
		runtime_nxt = runtime_r;
		if (cmd_take && cmd_overwrites(rx_byte)) begin
			runtime_nxt = RUNTIME_ZERO;
		end else if (run_start) begin
			runtime_nxt = RUNTIME_ZERO;
		end else if (!debug_mode && runtime_r != RUNTIME_MAX) begin
			runtime_nxt = runtime_r + 16'h0001;
		end
	end

	// Link state and byte count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			cnt_r   <= 2'd0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// Answer shifter, also collects watch write bytes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			resp_r <= 24'h00_0000;
		end else begin
			resp_r <= resp_nxt;
		end
	end

	// Marks a status answer in flight
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_ans_r <= 1'b0;
		end else begin
			stat_ans_r <= stat_ans_nxt;
		end
	end

	// Watch registers change only on a complete write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			watch_r <= {WATCH_RESET, WATCH_RESET, WATCH_RESET};
		end else begin
			watch_r <= watch_nxt;
		end
	end

	// Runtime counter and debug mode history
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			runtime_r <= RUNTIME_ZERO;
			dbg_q_r   <= 1'b0;
		end else begin
			runtime_r <= runtime_nxt;
			dbg_q_r   <= debug_mode;
		end
	end

	// Hit flag: a new hit in the cycle the status read finishes is kept
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hit_r <= 1'b0;
		end else begin
			hit_r <= watch_hit | (hit_r & ~status_done);
		end
	end

	// Registered so the break pulse is glitch free
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			break_r <= 1'b0;
		end else begin
			break_r <= watch_hit;
		end
	end
endmodule : dbgw_core
`default_nettype wire

// [dbgw_pkg.sv]
package dbgw_pkg;
	localparam logic [7:0] CMD_READ_REV     = 8'h00;
	localparam logic [7:0] CMD_READ_STATUS  = 8'h02;
	localparam logic [7:0] CMD_READ_RUNTIME = 8'h03;
	localparam logic [7:0] CMD_WR_PROG      = 8'h0A;
	localparam logic [7:0] CMD_RD_CRC       = 8'h0E;
	localparam logic [7:0] CMD_STEP         = 8'h10;
	localparam logic [7:0] CMD_EXEC         = 8'h12;
	localparam logic [7:0] CMD_WR_REG       = 8'h08;
	localparam logic [7:0] CMD_RD_REG       = 8'h09;
	localparam logic [7:0] CMD_WR_WATCH     = 8'h20;
	localparam logic [7:0] CMD_RD_WATCH     = 8'h21;
	localparam logic [15:0] RUNTIME_ZERO    = 16'h0000;
	localparam logic [15:0] RUNTIME_MAX     = 16'hFFFF;
	localparam logic [7:0] WATCH_RESET      = 8'h00;
	localparam int CTL_ADDR_HI_MSB          = 3;
	localparam int CTL_DATA_MATCH_BIT       = 5;
	localparam int CTL_WATCH_EN_BIT         = 7;
	localparam int STAT_DEBUG_BIT           = 7;
	localparam int STAT_HIT_BIT             = 6;
	localparam logic [1:0] WATCH_BYTES      = 2'd3;

	typedef struct packed {
		logic [7:0] control;
		logic [7:0] addr_low;
		logic [7:0] data;
	} dbgw_watch_t;

	typedef struct packed {
		logic        valid;
		logic [11:0] addr;
		logic [7:0]  data;
	} dbgw_rf_access_t;
endpackage : dbgw_pkg

// [dbgw_core_properties.sv]
`timescale 1ns/1ns
`default_nettype none
module dbgw_core_properties
	import dbgw_pkg::*;
(
	input wire logic            clk, rst_n, rx_valid, tx_valid, tx_ready, debug_mode, watch_break,
	input wire logic [7:0]      rx_byte, tx_byte, debugger_status_byte,
	input wire dbgw_rf_access_t rf_access
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_wait; tx_valid && !tx_ready; endsequence
	property p_hold; s_wait |=> tx_valid && $stable(tx_byte); endproperty
	property p_rise; $rose(tx_valid) |-> $past(rx_valid); endproperty
	property p_fall; $fell(tx_valid) |-> $past(tx_ready); endproperty
	property p_stat; debugger_status_byte[7] == debug_mode; endproperty
	property p_hit; watch_break |-> debugger_status_byte[6]; endproperty
	property p_cause; watch_break |-> $past(rf_access.valid); endproperty
	property p_pulse; watch_break |=> !watch_break; endproperty
	// Hit may only clear while an answer byte is offered
	property p_stick; debugger_status_byte[6] && !tx_valid |=> debugger_status_byte[6]; endproperty
	a_hold: assert property (p_hold) else $error("answer byte dropped");
	a_rise: assert property (p_rise) else $error("answer without command");
	a_fall: assert property (p_fall) else $error("answer withdrawn");
	a_stat: assert property (p_stat) else $error("status debug bit wrong");
	a_hit: assert property (p_hit) else $error("hit flag missing");
	a_cause: assert property (p_cause) else $error("break without access");
	a_pulse: assert property (p_pulse) else $error("break too long");
	a_stick: assert property (p_stick) else $error("hit flag lost");
endmodule : dbgw_core_properties
`default_nettype wire

// [dbgw_host.sv]
`timescale 1ns/1ns
`default_nettype none
module dbgw_host (
	input  wire logic       clk,
	output logic            rx_valid,
	output logic [7:0]      rx_byte,
	output logic            tx_ready,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_byte
);
	initial begin
		rx_valid = 0;
		rx_byte = 8'h00;
		tx_ready = 0;
	end
	// Command byte goes out before any answer is awaited
	task automatic send(input logic [7:0] v);
		@(negedge clk);
		rx_valid = 1;
		rx_byte = v;
		@(negedge clk);
		rx_valid = 0;
		rx_byte = ~v;  // Released lines must not look like a fresh byte
	endtask : send
	// Answers taken in order, optionally stalled
	task automatic get(input int d, output logic [7:0] v);
		v = 'x;
		repeat (d) @(negedge clk);
		for (int i = 0; i < 20; i++) begin
			@(negedge clk);
			if (tx_valid) begin
				v = tx_byte;
				tx_ready = 1;
				break;
			end
		end
		@(negedge clk);
		tx_ready = 0;
	endtask : get
endmodule : dbgw_host
`default_nettype wire

// [dbgw_core_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module dbgw_core_tb_top;
	import dbgw_pkg::*;
	logic            clk, rst_n, rx_valid, tx_valid, tx_ready, debug_mode, watch_break;
	logic [7:0]      rx_byte, tx_byte, debugger_status_byte, v;
	dbgw_rf_access_t rf_access;
	int              error_cnt, num_checks;
	dbgw_core #(.REVISION(16'hA55A)) dbgw_core_inst (.clk, .rst_n, .rx_valid, .rx_byte,
		.tx_valid, .tx_byte, .tx_ready, .debug_mode, .rf_access, .watch_break,
		.debugger_status_byte);
	dbgw_host dbgw_host_inst (.clk, .rx_valid, .rx_byte, .tx_ready, .tx_valid, .tx_byte);
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic end_sim;
		$display("errors %0d checks %0d", error_cnt, num_checks);
		if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task automatic rd(input logic [7:0] c, input logic [7:0] a, input logic [7:0] b);
		dbgw_host_inst.send(c);
		dbgw_host_inst.get(0, v);
		chk(v, a);
		dbgw_host_inst.get(3, v);
		chk(v, b);
	endtask : rd
	task automatic wrw(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d);
		dbgw_host_inst.send(CMD_WR_WATCH);
		dbgw_host_inst.send(c);
		dbgw_host_inst.send(a);
		dbgw_host_inst.send(d);
	endtask : wrw
	task automatic acc(input logic [11:0] a, input logic [7:0] d, input logic e);
		@(negedge clk);
		rf_access = {1'b1, a, d};
		@(negedge clk);
		rf_access.valid = 0;
		chk({7'h00, watch_break}, {7'h00, e});
	endtask : acc
	task automatic t_watch;
		rd(CMD_RD_WATCH, 8'h00, 8'h00);  // Reset values
		dbgw_host_inst.get(0, v);
		chk(v, 8'h00);
		wrw(8'h83, 8'h45, 8'h99);
		acc(12'h345, 8'h11, 1);
		acc(12'h245, 8'h11, 0);
		acc(12'h344, 8'h11, 0);
		wrw(8'hA3, 8'h45, 8'h99);
		acc(12'h345, 8'h11, 0);
		acc(12'h345, 8'h99, 1);
		rd(CMD_RD_WATCH, 8'hA3, 8'h45);
		dbgw_host_inst.get(0, v);
		chk(v, 8'h99);
	endtask : t_watch
	task automatic t_run;
		for (int c = 8; c < 19; c++) begin
			if (c == 15) continue;
			@(negedge clk) debug_mode = 0;
			repeat (3) @(negedge clk);
			debug_mode = 1;
			dbgw_host_inst.send(8'(c));
			rd(CMD_READ_RUNTIME, 8'h00, 8'h00);
		end
		@(negedge clk) debug_mode = 0;
		repeat (70000) @(negedge clk);  // Past 16 bits, so a wrap would show
		debug_mode = 1;
		rd(CMD_READ_RUNTIME, 8'hFF, 8'hFF);
	endtask : t_run
	initial begin
		#1_000_000;
		error_cnt++;
		end_sim();
	end
	initial begin
		rst_n = 0;
		debug_mode = 1;
		rf_access = '0;
		repeat (12) @(posedge clk);
		@(negedge clk) rst_n = 1;
		rd(CMD_READ_REV, 8'hA5, 8'h5A);
		t_watch();
		dbgw_host_inst.send(CMD_READ_STATUS);
		dbgw_host_inst.get(0, v);
		chk(v, 8'hC0);
		dbgw_host_inst.send(CMD_READ_STATUS);
		dbgw_host_inst.get(0, v);
		chk(v, 8'h80);
		t_run();
		end_sim();
	end
endmodule : dbgw_core_tb_top
bind dbgw_core dbgw_core_properties dbgw_core_properties_inst (.clk, .rst_n, .rx_valid,
	.tx_valid, .tx_ready, .debug_mode, .watch_break, .rx_byte, .tx_byte,
	.debugger_status_byte, .rf_access);
`default_nettype wire
